//--- core/tmr_pkg.sv
/*
 Constants, field positions and carrier types for the dual timer/counter
 control block. Assumes a byte-wide special-function register port.
*/
package tmr_pkg;

    // Register addresses
    localparam logic [7:0] ADDR_TCTL  = 8'h88;
    localparam logic [7:0] ADDR_TMODE = 8'h89;
    localparam logic [7:0] ADDR_TL0   = 8'h8a;
    localparam logic [7:0] ADDR_TL1   = 8'h8b;
    localparam logic [7:0] ADDR_TH0   = 8'h8c;
    localparam logic [7:0] ADDR_TH1   = 8'h8d;
    localparam logic [7:0] ADDR_ISTAT = 8'h90;
    localparam logic [7:0] ADDR_IMASK = 8'h91;

    // Reset values
    localparam logic [7:0] TCTL_RST  = 8'h00;
    localparam logic [7:0] TMODE_RST = 8'h00;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [3:0] IRQ_RST   = 4'h0;

    // timer_control bit positions
    localparam int TC_TF1 = 7;
    localparam int TC_TR1 = 6;
    localparam int TC_TF0 = 5;
    localparam int TC_TR0 = 4;
    localparam int TC_IE1 = 3;
    localparam int TC_IT1 = 2;
    localparam int TC_IE0 = 1;
    localparam int TC_IT0 = 0;

    // timer_mode halves: timer 1 high nibble, timer 0 low nibble
    localparam int TM_T1_LSB = 4;
    localparam int TM_T0_LSB = 0;

    // Operating modes
    localparam logic [1:0] MODE_PRESCALE = 2'h0;
    localparam logic [1:0] MODE_16BIT    = 2'h1;
    localparam logic [1:0] MODE_RELOAD   = 2'h2;
    localparam logic [1:0] MODE_SPLIT    = 2'h3;

    // Interrupt status bits
    localparam int IRQ_TF0 = 0;
    localparam int IRQ_TF1 = 1;
    localparam int IRQ_IE0 = 2;
    localparam int IRQ_IE1 = 3;

    // Internal count source: one tick every INT_TICK_DIV clocks
    localparam logic [3:0] INT_TICK_DIV = 4'hc;
    localparam logic [3:0] INT_TICK_TOP = INT_TICK_DIV - 4'h1;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    typedef struct packed {
        logic       gate;
        logic       src;
        logic [1:0] mode;
    } mode_half_t;

endpackage : tmr_pkg

//--- core/count_core.sv
/*
 Next-value logic for one timer's low and high count bytes.
 Assumes the caller gates step and decides what mode 3 means for it.
*/
`timescale 1ns/1ps
module count_core (
    input  wire logic [1:0] mode,
    input  wire logic       step,
    input  wire logic [7:0] lo,
    input  wire logic [7:0] hi,
    output logic      [7:0] lo_nxt,
    output logic      [7:0] hi_nxt,
    output logic            ovf
);
    wire logic        pre_full = &lo[4:0];
    wire logic [15:0] wide_inc = {hi, lo} + 16'h0001;

    always_comb begin
        lo_nxt = lo;
        hi_nxt = hi;
        ovf    = 1'b0;
        if (step) begin
            unique case (mode)
                tmr_pkg::MODE_PRESCALE: begin
                    // Upper three low-byte bits are left alone
                    lo_nxt = {lo[7:5], 5'(lo[4:0] + 5'h01)};
                    hi_nxt = pre_full ? 8'(hi + 8'h01) : hi;
                    ovf    = pre_full & (&hi);
                end
                tmr_pkg::MODE_16BIT: begin
                    {hi_nxt, lo_nxt} = wide_inc;
                    ovf              = &{hi, lo};
                end
                tmr_pkg::MODE_RELOAD: begin
                    // Reload from the high byte, which stays put
                    ovf    = &lo;
                    lo_nxt = (&lo) ? hi : 8'(lo + 8'h01);
                end
                tmr_pkg::MODE_SPLIT: begin
                    ovf    = &lo;
                    lo_nxt = 8'(lo + 8'h01);
                end
            endcase
        end
    end

endmodule : count_core

//--- core/dual_timer_counter_control.sv
/*
 Control and count registers for two timer/counters and two external
 interrupt inputs. Assumes pins synchronous to mclk and one-cycle vector
 acknowledge pulses from the interrupt controller.
*/
// The plain strobed port was left to the implementer.
// Operation
// - Overflow flag clears when the processor vectors to that timer's handler.
// - Timer 0 overflow sets control bit 5.
// - Timer 1 overflow sets control bit 7.
// - Run bits 6 and 4 start and stop timers 1 and 0.
// - Detected external interrupt sets bit 3 (pin 1) or bit 1 (pin 0).
// - External flag clears on servicing only when edge triggered.
// - Timer 1 mode bits 5:4 pick prescaled, 16-bit, reload, or halt.
// - Timer 0 mode bits 1:0, code 11 splits into two 8-bit counters.
// - Control, mode and count bytes reset to zero.
// - Mode 0 is 8-bit high byte behind a divide-by-32 low-byte prescaler.
// - Mode 2 low-byte overflow sets flag and reloads from high byte.
// - Timer 0 split: high byte counts internal ticks under timer 1 controls.
`timescale 1ns/1ps
module dual_timer_counter_control (
    input  wire logic              mclk,
    input  wire logic              nrst,
    input  wire logic              ce,
    input  wire tmr_pkg::reg_req_t req,
    output logic             [7:0] rdata,
    input  wire logic              ext_irq0_pin,
    input  wire logic              ext_irq1_pin,
    input  wire logic              t0_count_pin,
    input  wire logic              t1_count_pin,
    input  wire logic              vec_t0_ack,
    input  wire logic              vec_t1_ack,
    input  wire logic              vec_x0_ack,
    input  wire logic              vec_x1_ack,
    output logic             [3:0] flag_req,
    output logic                   irq
);
    logic [7:0] tctl_r, tmode_r, tl0_r, th0_r, tl1_r, th1_r, rdata_r;
    logic [3:0] istat_r, imask_r, tick_cnt_r;
    logic       x0_prev_r, x1_prev_r, c0_prev_r, c1_prev_r;

    // Register decode
    wire logic wr_tctl  = req.wr & (req.addr == tmr_pkg::ADDR_TCTL);
    wire logic wr_tmode = req.wr & (req.addr == tmr_pkg::ADDR_TMODE);
    wire logic wr_tl0   = req.wr & (req.addr == tmr_pkg::ADDR_TL0);
    wire logic wr_tl1   = req.wr & (req.addr == tmr_pkg::ADDR_TL1);
    wire logic wr_th0   = req.wr & (req.addr == tmr_pkg::ADDR_TH0);
    wire logic wr_th1   = req.wr & (req.addr == tmr_pkg::ADDR_TH1);
    wire logic wr_imask = req.wr & (req.addr == tmr_pkg::ADDR_IMASK);
    wire logic rd_istat = req.rd & (req.addr == tmr_pkg::ADDR_ISTAT);

    // Mode fields
    wire tmr_pkg::mode_half_t m1 = tmode_r[tmr_pkg::TM_T1_LSB +: 4];
    wire tmr_pkg::mode_half_t m0 = tmode_r[tmr_pkg::TM_T0_LSB +: 4];
    wire logic t0_split = (m0.mode == tmr_pkg::MODE_SPLIT);

    wire logic tr0 = tctl_r[tmr_pkg::TC_TR0];
    wire logic tr1 = tctl_r[tmr_pkg::TC_TR1];
    wire logic it0 = tctl_r[tmr_pkg::TC_IT0];
    wire logic it1 = tctl_r[tmr_pkg::TC_IT1];

    // Internal divided clock
    wire logic tick = (tick_cnt_r == tmr_pkg::INT_TICK_TOP);
    wire logic [3:0] tick_nxt = tick ? 4'h0 : 4'(tick_cnt_r + 4'h1);

    // Count sources: falling edges on the count pins or the internal tick
    wire logic c0_fall = c0_prev_r & ~t0_count_pin;
    wire logic c1_fall = c1_prev_r & ~t1_count_pin;
    wire logic src0 = m0.src ? c0_fall : tick;
    wire logic src1 = m1.src ? c1_fall : tick;

    // Run and gating
    wire logic en0 = tr0 & (~m0.gate | ext_irq0_pin);
    wire logic en1 = tr1 & (~m1.gate | ext_irq1_pin);
    wire logic step0 = en0 & src0;
    // Mode 3 of timer 1 holds the count
    wire logic step1 = en1 & src1 & (m1.mode != tmr_pkg::MODE_SPLIT);

    logic [7:0] tl0_c, th0_c, tl1_c, th1_c;
    logic       ovf0_c, ovf1_c;

    count_core u_cnt0 (
        .mode   (m0.mode),
        .step   (step0),
        .lo     (tl0_r),
        .hi     (th0_r),
        .lo_nxt (tl0_c),
        .hi_nxt (th0_c),
        .ovf    (ovf0_c)
    );

    count_core u_cnt1 (
        .mode   (m1.mode),
        .step   (step1),
        .lo     (tl1_r),
        .hi     (th1_r),
        .lo_nxt (tl1_c),
        .hi_nxt (th1_c),
        .ovf    (ovf1_c)
    );

    // Split mode: high byte of timer 0 borrows timer 1's run and flag
    wire logic       hs_step = t0_split & tr1 & tick;
    wire logic       hs_ovf  = hs_step & (&th0_r);
    wire logic [7:0] th0_hs  = hs_step ? 8'(th0_r + 8'h01) : th0_r;

    // Overflow events; timer 1 loses its flag while timer 0 is split
    wire logic ovf0_ev = ovf0_c;
    wire logic ovf1_ev = t0_split ? hs_ovf : ovf1_c;

    // Count byte next values; a software write wins over counting
    wire logic [7:0] tl0_nxt = wr_tl0 ? req.wdata : tl0_c;
    wire logic [7:0] th0_nxt = wr_th0 ? req.wdata : (t0_split ? th0_hs : th0_c);
    wire logic [7:0] tl1_nxt = wr_tl1 ? req.wdata : tl1_c;
    wire logic [7:0] th1_nxt = wr_th1 ? req.wdata : th1_c;

    // External interrupt detection
    wire logic x0_fall = x0_prev_r & ~ext_irq0_pin;
    wire logic x1_fall = x1_prev_r & ~ext_irq1_pin;
    wire logic x0_det  = it0 ? x0_fall : ~ext_irq0_pin;
    wire logic x1_det  = it1 ? x1_fall : ~ext_irq1_pin;

    // Flags: a hardware set always beats a clear in the same cycle
    wire logic tf0_hold = wr_tctl ? req.wdata[tmr_pkg::TC_TF0]
                                  : tctl_r[tmr_pkg::TC_TF0] & ~vec_t0_ack;
    wire logic tf1_hold = wr_tctl ? req.wdata[tmr_pkg::TC_TF1]
                                  : tctl_r[tmr_pkg::TC_TF1] & ~vec_t1_ack;
    wire logic ie0_hold = wr_tctl ? req.wdata[tmr_pkg::TC_IE0]
                                  : tctl_r[tmr_pkg::TC_IE0] & ~(vec_x0_ack & it0);
    wire logic ie1_hold = wr_tctl ? req.wdata[tmr_pkg::TC_IE1]
                                  : tctl_r[tmr_pkg::TC_IE1] & ~(vec_x1_ack & it1);
    // Level mode flag tracks the pin so it drops once the pin is released
    wire logic ie0_nxt = it0 ? (x0_det | ie0_hold) : x0_det;
    wire logic ie1_nxt = it1 ? (x1_det | ie1_hold) : x1_det;
    wire logic tf0_nxt = ovf0_ev | tf0_hold;
    wire logic tf1_nxt = ovf1_ev | tf1_hold;

    wire logic [7:0] tctl_nxt = {
        tf1_nxt,
        wr_tctl ? req.wdata[tmr_pkg::TC_TR1] : tr1,
        tf0_nxt,
        wr_tctl ? req.wdata[tmr_pkg::TC_TR0] : tr0,
        ie1_nxt,
        wr_tctl ? req.wdata[tmr_pkg::TC_IT1] : it1,
        ie0_nxt,
        wr_tctl ? req.wdata[tmr_pkg::TC_IT0] : it0
    };

    // Sticky interrupt status: new events survive a clearing read
    wire logic [3:0] ev = {
        ie1_nxt & ~tctl_r[tmr_pkg::TC_IE1],
        ie0_nxt & ~tctl_r[tmr_pkg::TC_IE0],
        ovf1_ev,
        ovf0_ev
    };
    wire logic [3:0] istat_nxt = ev | (rd_istat ? 4'h0 : istat_r);
    wire logic [3:0] imask_nxt = wr_imask ? req.wdata[3:0] : imask_r;

    // Read mux; unmapped addresses read zero
    logic [7:0] rmux;
    always_comb begin
        unique case (req.addr)
            tmr_pkg::ADDR_TCTL:  rmux = tctl_r;
            tmr_pkg::ADDR_TMODE: rmux = tmode_r;
            tmr_pkg::ADDR_TL0:   rmux = tl0_r;
            tmr_pkg::ADDR_TL1:   rmux = tl1_r;
            tmr_pkg::ADDR_TH0:   rmux = th0_r;
            tmr_pkg::ADDR_TH1:   rmux = th1_r;
            tmr_pkg::ADDR_ISTAT: rmux = {4'h0, istat_r};
            tmr_pkg::ADDR_IMASK: rmux = {4'h0, imask_r};
            default:             rmux = 8'h00;
        endcase
    end
    wire logic [7:0] rdata_nxt = req.rd ? rmux : 8'h00;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            tctl_r  <= tmr_pkg::TCTL_RST;
            tmode_r <= tmr_pkg::TMODE_RST;
            tl0_r   <= tmr_pkg::COUNT_RST;
            th0_r   <= tmr_pkg::COUNT_RST;
            tl1_r   <= tmr_pkg::COUNT_RST;
            th1_r   <= tmr_pkg::COUNT_RST;
        end else if (ce) begin
            tctl_r  <= tctl_nxt;
            tmode_r <= wr_tmode ? req.wdata : tmode_r;
            tl0_r   <= tl0_nxt;
            th0_r   <= th0_nxt;
            tl1_r   <= tl1_nxt;
            th1_r   <= th1_nxt;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            istat_r    <= tmr_pkg::IRQ_RST;
            imask_r    <= tmr_pkg::IRQ_RST;
            rdata_r    <= 8'h00;
            tick_cnt_r <= 4'h0;
            x0_prev_r  <= 1'b1;
            x1_prev_r  <= 1'b1;
            c0_prev_r  <= 1'b1;
            c1_prev_r  <= 1'b1;
        end else if (ce) begin
            istat_r    <= istat_nxt;
            imask_r    <= imask_nxt;
            rdata_r    <= rdata_nxt;
            tick_cnt_r <= tick_nxt;
            x0_prev_r  <= ext_irq0_pin;
            x1_prev_r  <= ext_irq1_pin;
            c0_prev_r  <= t0_count_pin;
            c1_prev_r  <= t1_count_pin;
        end
    end

    assign rdata    = rdata_r;
    assign flag_req = {tctl_r[tmr_pkg::TC_TF1], tctl_r[tmr_pkg::TC_IE1],
                       tctl_r[tmr_pkg::TC_TF0], tctl_r[tmr_pkg::TC_IE0]};
    assign irq      = |(istat_r & imask_r);

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    a_tf0_on_ovf: assert property (ce && ovf0_ev |=> tctl_r[tmr_pkg::TC_TF0])
        else $error("timer 0 overflow did not set its flag");
    a_tf1_on_ovf: assert property (ce && ovf1_ev |=> tctl_r[tmr_pkg::TC_TF1])
        else $error("timer 1 overflow did not set its flag");
    a_tf0_vector_clear: assert property (
        ce && vec_t0_ack && !ovf0_ev && !wr_tctl |=> !tctl_r[tmr_pkg::TC_TF0])
        else $error("vectoring did not clear timer 0 flag");
    a_stop_holds_low: assert property (
        ce && !tr0 && !wr_tl0 |=> $stable(tl0_r))
        else $error("timer 0 low byte moved while stopped");
    a_gate_blocks_count: assert property (
        ce && m0.gate && !ext_irq0_pin && !wr_tl0 |=> tl0_r == $past(tl0_r))
        else $error("gated timer 0 counted with pin low");
    a_edge_sets_ie1: assert property (
        ce && it1 && x1_fall |=> tctl_r[tmr_pkg::TC_IE1])
        else $error("falling edge on pin 1 not flagged");
    a_edge_ack_clear: assert property (
        ce && it0 && vec_x0_ack && !x0_fall && !wr_tctl
        |=> !tctl_r[tmr_pkg::TC_IE0])
        else $error("edge flag 0 not cleared on service");
    a_level_ack_keeps: assert property (
        ce && !it0 && !ext_irq0_pin && !wr_tctl ##1 ce && !ext_irq0_pin
        |-> tctl_r[tmr_pkg::TC_IE0])
        else $error("level flag 0 dropped while pin low");
    a_t1_halt_hold: assert property (
        ce && m1.mode == tmr_pkg::MODE_SPLIT && !wr_tl1 && !wr_th1
        |=> $stable({th1_r, tl1_r}))
        else $error("timer 1 moved while halted");
    a_reload_from_hi: assert property (
        ce && m0.mode == tmr_pkg::MODE_RELOAD && ovf0_c && !wr_tl0 && !wr_th0
        |=> tl0_r == $past(th0_r) && th0_r == $past(th0_r))
        else $error("mode 2 reload wrong");
    a_prescale_carry: assert property (
        ce && m1.mode == tmr_pkg::MODE_PRESCALE && step1 && tl1_r[4:0] == 5'h1f
        && !wr_th1 && !wr_tl1 |=> th1_r == 8'($past(th1_r) + 8'h01) && tl1_r[4:0] == 5'h00)
        else $error("mode 0 prescaler carry wrong");
    a_split_hi_count: assert property (
        ce && t0_split && tr1 && tick && !wr_th0 |=> th0_r == 8'($past(th0_r) + 8'h01))
        else $error("split high byte did not count");
    a_reset_zero: assert property ($rose(nrst) |-> tctl_r == 8'h00 && tmode_r == 8'h00)
        else $error("registers not zero after reset");

    c_t0_overflow: cover property (ce && ovf0_ev);
    c_reload_mode: cover property (ce && m1.mode == tmr_pkg::MODE_RELOAD && ovf1_c);
    c_split_hi_ovf: cover property (ce && hs_ovf);
    a_tf1_vector_clear: assert property (
        ce && vec_t1_ack && !ovf1_ev && !wr_tctl |=> !tctl_r[tmr_pkg::TC_TF1])
        else $error("vectoring did not clear timer 1 flag");
    a_mode1_wrap: assert property (
        ce && m0.mode == tmr_pkg::MODE_16BIT && step0 && {th0_r, tl0_r} == 16'hffff
        && !wr_tl0 && !wr_th0 |=> tl0_r == 8'h00 && th0_r == 8'h00 && tctl_r[tmr_pkg::TC_TF0])
        else $error("timer 0 16-bit wrap wrong");
    a_t1_stop_holds: assert property (
        ce && !tr1 && !wr_tl1 |=> $stable(tl1_r))
        else $error("timer 1 low byte moved while stopped");
    a_timer1_pin_gating_blocks: assert property (
        ce && m1.gate && !ext_irq1_pin && !wr_tl1 |=> $stable(tl1_r))
        else $error("gated timer 1 counted with pin low");
    a_edge_sets_ie0: assert property (
        ce && it0 && x0_fall |=> tctl_r[tmr_pkg::TC_IE0])
        else $error("falling edge on pin 0 not flagged");
    a_edge_ack_clear1: assert property (
        ce && it1 && vec_x1_ack && !x1_fall && !wr_tctl |=> !tctl_r[tmr_pkg::TC_IE1])
        else $error("edge flag 1 not cleared on service");
    a_level_det_ie0: assert property (
        ce && !it0 && !wr_tctl |=> tctl_r[tmr_pkg::TC_IE0] == !$past(ext_irq0_pin))
        else $error("level flag 0 does not follow pin");
    a_level_det_ie1: assert property (
        ce && !it1 && !wr_tctl |=> tctl_r[tmr_pkg::TC_IE1] == !$past(ext_irq1_pin))
        else $error("level flag 1 does not follow pin");
    a_ext_src_idle: assert property (
        ce && m0.src && !c0_fall && !wr_tl0 |=> $stable(tl0_r))
        else $error("counter 0 moved without a pin edge");
    a_int_src_idle: assert property (
        ce && !m0.src && !tick && !wr_tl0 |=> $stable(tl0_r))
        else $error("timer 0 moved without a tick");
    a_t1_reload: assert property (
        ce && m1.mode == tmr_pkg::MODE_RELOAD && ovf1_c && !wr_tl1 && !wr_th1
        |=> tl1_r == $past(th1_r) && th1_r == $past(th1_r))
        else $error("timer 1 mode 2 reload wrong");
    a_split_hi_hold: assert property (
        ce && t0_split && !tr1 && !wr_th0 |=> $stable(th0_r))
        else $error("split high byte moved while timer 1 run clear");
    a_prescale_t0: assert property (
        ce && m0.mode == tmr_pkg::MODE_PRESCALE && step0 && tl0_r[4:0] == 5'h1f
        && !wr_th0 && !wr_tl0 |=> th0_r == 8'($past(th0_r) + 8'h01))
        else $error("timer 0 prescaler carry wrong");
    a_upper_lo_kept: assert property (
        ce && m0.mode == tmr_pkg::MODE_PRESCALE && !wr_tl0 |=> $stable(tl0_r[7:5]))
        else $error("ignored low-byte bits changed");
    a_reset_counts: assert property (
        $rose(nrst) |-> tl0_r == 8'h00 && th0_r == 8'h00 && tl1_r == 8'h00 && th1_r == 8'h00)
        else $error("count bytes not zero after reset");

    c_irq_raised: cover property (!irq ##1 irq);
    c_ext_edge: cover property (ce && it1 && x1_fall);

endmodule : dual_timer_counter_control

//--- tb/pin_model.sv
/*
 Far-side pin model: timer count pins and external interrupt/gate pins.
 Assumes one clock and bench commands changed just after rising edges.
*/
`timescale 1ns/1ps
module pin_model (
    input  wire logic       mclk,
    input  wire logic       nrst,
    input  wire logic [1:0] cnt_go,
    input  wire logic       slow,
    input  wire logic [1:0] irq_lvl,
    output logic            t0_count_pin,
    output logic            t1_count_pin,
    output logic            ext_irq0_pin,
    output logic            ext_irq1_pin
);
    logic [2:0] low0_r;
    logic [2:0] low1_r;
    // Pins are pulled up, so idle level is high
    assign t0_count_pin = (low0_r == 3'h0);
    assign t1_count_pin = (low1_r == 3'h0);
    // Slow pulses stay low for several cycles, so one edge must count once
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            low0_r       <= 3'h0;
            low1_r       <= 3'h0;
            ext_irq0_pin <= 1'b1;
            ext_irq1_pin <= 1'b1;
        end else begin
            low0_r       <= cnt_go[0] ? (slow ? 3'h4 : 3'h1) : low0_r - {2'h0, |low0_r};
            low1_r       <= cnt_go[1] ? (slow ? 3'h4 : 3'h1) : low1_r - {2'h0, |low1_r};
            ext_irq0_pin <= irq_lvl[0];
            ext_irq1_pin <= irq_lvl[1];
        end
    end
endmodule : pin_model

//--- tb/tb_top.sv
/*
 Self-checking bench for the dual timer/counter control block.
 Assumes the pin model on the far side and a one-cycle read latency.
*/
`timescale 1ns/1ps
module tb_top;
    logic              mclk;
    logic              nrst;
    logic              ce;
    tmr_pkg::reg_req_t req;
    logic [7:0]        rdata;
    logic [3:0]        flag_req;
    logic              irq;
    logic [3:0]        ack_r;
    logic [1:0]        cnt_go;
    logic              slow;
    logic [1:0]        irq_lvl;
    logic              t0p;
    logic              t1p;
    logic              x0p;
    logic              x1p;
    logic [15:0]       exp_q[$];
    logic [15:0]       e;
    logic              rd_seen;
    logic [7:0]        v;
    logic [7:0]        amap[8];
    int                fail_count;
    int                n_compared;
    int                cyc;
    int                seed;

    dual_timer_counter_control DUT (.mclk(mclk), .nrst(nrst), .ce(ce), .req(req),
        .rdata(rdata), .ext_irq0_pin(x0p), .ext_irq1_pin(x1p), .t0_count_pin(t0p),
        .t1_count_pin(t1p), .vec_t0_ack(ack_r[0]), .vec_t1_ack(ack_r[1]),
        .vec_x0_ack(ack_r[2]), .vec_x1_ack(ack_r[3]), .flag_req(flag_req), .irq(irq));
    pin_model pins (.mclk(mclk), .nrst(nrst), .cnt_go(cnt_go), .slow(slow),
        .irq_lvl(irq_lvl), .t0_count_pin(t0p), .t1_count_pin(t1p),
        .ext_irq0_pin(x0p), .ext_irq1_pin(x1p));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [7:0] g, input logic [7:0] x);
        n_compared++;
        if (g !== x) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask : chk

    task automatic step(input int k);
        repeat (k) @(posedge mclk);
    endtask : step

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        req.wr <= 1'b0;
    endtask : wr

    // Expected value queued with the strobe; the monitor pops it
    task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic [7:0] m);
        @(posedge mclk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        exp_q.push_back({m, x});
        @(posedge mclk);
        req.rd <= 1'b0;
    endtask : rd

    task automatic flg(input int b, input logic [7:0] x);
        @(negedge mclk);
        chk({7'h00, flag_req[b]}, x);
    endtask : flg

    task automatic wait_flag(input int b);
        for (int k = 0; k < 100 && flag_req[b] !== 1'b1; k++) @(negedge mclk);
        chk({7'h00, flag_req[b]}, 8'h01);
    endtask : wait_flag

    task automatic ack(input int i);
        @(posedge mclk);
        ack_r[i] <= 1'b1;
        @(posedge mclk);
        ack_r[i] <= 1'b0;
    endtask : ack

    // Gap after each pulse keeps consecutive falling edges distinct
    task automatic pulse(input int i, input logic s);
        @(posedge mclk);
        cnt_go[i] <= 1'b1;
        slow      <= s;
        @(posedge mclk);
        cnt_go[i] <= 1'b0;
        step(8);
    endtask : pulse

    always @(posedge mclk) rd_seen <= req.rd & ce;
    always @(negedge mclk) begin
        if (rd_seen) begin
            e = exp_q.pop_front();
            chk(rdata & e[15:8], e[7:0]);
        end
    end

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            end_sim();
        end
    end

    initial begin
        nrst = 1'b0; ce = 1'b1; req = '0; ack_r = 4'h0; cnt_go = 2'h0;
        slow = 1'b0; irq_lvl = 2'h3; seed = 45005; rd_seen = 1'b0;
        amap = '{tmr_pkg::ADDR_TCTL, tmr_pkg::ADDR_TMODE, tmr_pkg::ADDR_TL0,
                 tmr_pkg::ADDR_TL1, tmr_pkg::ADDR_TH0, tmr_pkg::ADDR_TH1,
                 tmr_pkg::ADDR_ISTAT, 8'h80};
        step(10);
        nrst <= 1'b1;
        foreach (amap[i]) rd(amap[i], 8'h00, 8'hff);
        v = 8'($random(seed));
        wr(tmr_pkg::ADDR_TMODE, v);
        rd(tmr_pkg::ADDR_TMODE, v, 8'hff);
        $display("test reset done");
        v = 8'h00 - 8'(1 + ($random(seed) & 3));
        wr(tmr_pkg::ADDR_TMODE, 8'h01);
        wr(tmr_pkg::ADDR_TL0, v);
        wr(tmr_pkg::ADDR_TH0, 8'hff);
        wr(tmr_pkg::ADDR_IMASK, 8'h01);
        wr(tmr_pkg::ADDR_TCTL, 8'h10);
        wait_flag(1);
        wr(tmr_pkg::ADDR_TCTL, 8'h20);
        @(negedge mclk);
        chk({7'h00, irq}, 8'h01);
        rd(tmr_pkg::ADDR_TCTL, 8'h20, 8'hff);
        rd(tmr_pkg::ADDR_TH0, 8'h00, 8'hff);
        rd(tmr_pkg::ADDR_ISTAT, 8'h01, 8'hff);
        step(2);
        @(negedge mclk);
        chk({7'h00, irq}, 8'h00);
        ack(0);
        flg(1, 8'h00);
        step(30);
        rd(tmr_pkg::ADDR_TL0, 8'h00, 8'hff);
        $display("test mode1 done");
        wr(tmr_pkg::ADDR_TMODE, 8'h20);
        wr(tmr_pkg::ADDR_TH1, 8'ha5);
        wr(tmr_pkg::ADDR_TL1, 8'hff);
        wr(tmr_pkg::ADDR_TCTL, 8'h40);
        wait_flag(3);
        wr(tmr_pkg::ADDR_TCTL, 8'h80);
        rd(tmr_pkg::ADDR_TL1, 8'ha5, 8'hff);
        rd(tmr_pkg::ADDR_TH1, 8'ha5, 8'hff);
        rd(tmr_pkg::ADDR_TCTL, 8'h80, 8'hff);
        ack(1);
        flg(3, 8'h00);
        wr(tmr_pkg::ADDR_TMODE, 8'h30);
        wr(tmr_pkg::ADDR_TL1, 8'h12);
        wr(tmr_pkg::ADDR_TCTL, 8'h40);
        step(30);
        rd(tmr_pkg::ADDR_TL1, 8'h12, 8'hff);
        $display("test timer1 done");
        wr(tmr_pkg::ADDR_TMODE, 8'h04);
        wr(tmr_pkg::ADDR_TL0, 8'hfe);
        wr(tmr_pkg::ADDR_TH0, 8'h07);
        wr(tmr_pkg::ADDR_TCTL, 8'h10);
        pulse(0, 1'b0);
        rd(tmr_pkg::ADDR_TL0, 8'h1f, 8'h1f);
        pulse(0, 1'b1);
        rd(tmr_pkg::ADDR_TL0, 8'h00, 8'h1f);
        rd(tmr_pkg::ADDR_TH0, 8'h08, 8'hff);
        $display("test mode0 done");
        wr(tmr_pkg::ADDR_TMODE, 8'h09);
        wr(tmr_pkg::ADDR_TL0, 8'hff);
        wr(tmr_pkg::ADDR_TH0, 8'hff);
        irq_lvl[0] <= 1'b0;
        wr(tmr_pkg::ADDR_TCTL, 8'h10);
        step(30);
        flg(1, 8'h00);
        irq_lvl[0] <= 1'b1;
        wait_flag(1);
        ack(0);
        $display("test gate done");
        for (int p = 0; p < 2; p++) begin
            for (int t = 0; t < 2; t++) begin
                wr(tmr_pkg::ADDR_TCTL, 8'(t << (2 * p)));
                irq_lvl[p] <= 1'b0;
                step(3);
                flg(2 * p, 8'h01);
                ack(2 + p);
                flg(2 * p, 8'(1 - t));
                irq_lvl[p] <= 1'b1;
                step(3);
                flg(2 * p, 8'h00);
            end
        end
        rd(tmr_pkg::ADDR_ISTAT, 8'h0f, 8'hff);
        rd(tmr_pkg::ADDR_IMASK, 8'h01, 8'hff);
        $display("test ext done");
        wr(tmr_pkg::ADDR_TMODE, 8'h03);
        wr(tmr_pkg::ADDR_TL0, 8'hff);
        wr(tmr_pkg::ADDR_TH0, 8'hff);
        wr(tmr_pkg::ADDR_TCTL, 8'h40);
        wait_flag(3);
        wr(tmr_pkg::ADDR_TCTL, 8'h80);
        rd(tmr_pkg::ADDR_TL0, 8'hff, 8'hff);
        rd(tmr_pkg::ADDR_TCTL, 8'h80, 8'hff);
        ack(1);
        flg(3, 8'h00);
        $display("test split done");
        step(4);
        end_sim();
    end
endmodule : tb_top
